// ===== logic/reset_generation.sv
/*
  Central reset generation: merges supply monitors, filtered pin, watchdog,
  software, option-byte, debugger and deep-sleep sources into five resets,
  records the last cause and flags CPU lockup.
  Assumes supply monitor levels already carry analog hysteresis and that the
  power manager drives the sleep phase levels.
*/
`timescale 1ns/1ps
`include "reset_gen_params.svh"

//Contract
// - Supply fail held from low threshold until supply passes the high threshold.
// - Always-on supply failure asserts all five resets.
// - Core and memory supply failures merge into one low-voltage source.
// - Low-voltage failure outside normal sleep wake asserts all five resets.
// - Low-voltage failure on sleep wake spares the retained peripheral reset.
// - Filtered pin resets all but the debug access port.
// - Pin lows of 26 us always reset; 1 us or less never.
// - Watchdog expiry resets CPU only, retained and core peripherals.
// - Software request resets CPU only, retained and core peripherals.
// - Option-byte failure resets CPU with debug, CPU only, core peripherals.
// - Option-byte failure retries; third consecutive failure stops into emulated sleep.
// - After stopping on failures, readout protection is forced active.
// - Normal deep sleep holds four resets until low-voltage monitors confirm.
// - Emulated deep sleep asserts only CPU only and core peripheral resets.
// - Debugger request asserts only the CPU only reset.
// - Tap reset only hits the TAP; ignored in serial-wire or disabled.
// - CPU reset pair: one with debug components, one without.
// - Retained peripherals and core peripherals have separate resets.
// - Debug access reset drives the bus access port.
// - The cause of the last restart is recorded; debugger requests and emulated sleep leave the recorded cause unchanged.
// - CPU lockup sets an indication, applies no reset.
module reset_generation (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire reset_gen_pkg::reset_src_t SOURCES,
  input wire logic EXT_PIN_RESET_N,
  input wire logic OPT_CHECK_DONE,
  input wire logic TAP_RESET_IN,
  input wire logic SERIAL_WIRE_MODE,
  input wire logic DEBUG_PORT_DISABLED,
  input wire logic CPU_LOCKUP,
  output reset_gen_pkg::reset_vec_t RESETS,
  output logic TAP_RESET,
  output logic [`CAUSE_W-1:0] LAST_CAUSE,
  output logic LOCKUP_FLAG,
  output logic FORCE_READ_PROTECT,
  output logic OPT_EMULATED_SLEEP
);
  import reset_gen_pkg::*;

  typedef struct packed {
    logic [`PIN_CNT_W-1:0] pin_count;
    logic pin_reset;
    logic [`OPT_CNT_W-1:0] opt_fails;
    opt_state_t opt_state;
    logic opt_seen;
    logic [`CAUSE_W-1:0] cause;
    logic lockup;
    logic tap_reset;
    logic wake_pending;
  } state_t;

  localparam logic [`PIN_CNT_W-1:0] PIN_LIMIT = `PIN_CNT_W'(`PIN_FILTER_CYCLES);

  state_t state;
  state_t next_state;
  logic low_volt_supply_fail;
  logic sleep_wake;
  reset_vec_t request;

  function automatic reset_vec_t pattern(input logic pd, input logic so, input logic da,
                                         input logic hv, input logic lv);
    reset_vec_t v;
    v.cpu_debug_reset = pd;
    v.cpu_only_reset = so;
    v.debug_access_reset = da;
    v.retained_periph_reset = hv;
    v.core_periph_reset = lv;
    return v;
  endfunction

  assign low_volt_supply_fail = SOURCES.core_supply_fail | SOURCES.mem_supply_fail;

  // Power drops inside a normal sleep cycle are not brown-outs
  assign sleep_wake = SOURCES.waking_from_sleep | SOURCES.normal_sleep | state.wake_pending;

  always_comb begin
    request = '0;
    if (SOURCES.always_on_supply_fail) begin
      request = request | pattern(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    end
    if (low_volt_supply_fail) begin
      request = request | pattern(1'b1, 1'b1, 1'b1, !sleep_wake, 1'b1);
    end
    if (state.pin_reset) begin
      request = request | pattern(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    end
    if (SOURCES.timer_expiry_reset || SOURCES.cpu_soft_reset_req) begin
      request = request | pattern(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    end
    if (SOURCES.config_check_fail && state.opt_state != OPT_STOPPED) begin
      request = request | pattern(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    end
    if (SOURCES.normal_sleep || (state.wake_pending && low_volt_supply_fail)) begin
      request = request | pattern(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    end
    if (SOURCES.emulated_sleep || state.opt_state == OPT_STOPPED) begin
      request = request | pattern(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    end
    if (SOURCES.debugger_reset_req) begin
      request = request | pattern(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    end
    if (!RESETN) begin
      request = pattern(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    end
  end

  always_comb begin
    next_state = state;
    // 12 us integration, reject 1 us
    if (!EXT_PIN_RESET_N) begin
      if (state.pin_count != PIN_LIMIT) begin
        next_state.pin_count = state.pin_count + `PIN_CNT_W'(1);
      end else begin
        next_state.pin_reset = 1'b1;
      end
    end else begin
      if (state.pin_count != '0) begin
        next_state.pin_count = state.pin_count - `PIN_CNT_W'(1);
      end else begin
        next_state.pin_reset = 1'b0;
      end
    end
    next_state.opt_seen = SOURCES.config_check_fail;
    unique case (state.opt_state)
      OPT_RUN, OPT_RETRY: begin
        if (SOURCES.config_check_fail && !state.opt_seen) begin
          if (state.opt_fails == `OPT_RETRY_LIMIT - `OPT_CNT_W'(1)) begin
            next_state.opt_state = OPT_STOPPED;
          end else begin
            next_state.opt_fails = state.opt_fails + `OPT_CNT_W'(1);
            next_state.opt_state = OPT_RETRY;
          end
        end else if (OPT_CHECK_DONE && !SOURCES.config_check_fail) begin
          next_state.opt_fails = '0;
          next_state.opt_state = OPT_RUN;
        end
      end
      OPT_STOPPED: begin
        next_state.opt_state = OPT_STOPPED;
      end
      default: begin
        next_state.opt_state = OPT_RUN;
      end
    endcase
    if (SOURCES.normal_sleep) begin
      next_state.wake_pending = 1'b1;
    end else if (!low_volt_supply_fail) begin
      next_state.wake_pending = 1'b0;
    end
    if (SOURCES.always_on_supply_fail) begin
      next_state.cause = `CAUSE_AON;
    end else if (low_volt_supply_fail && !sleep_wake) begin
      next_state.cause = `CAUSE_LOWV;
    end else if (SOURCES.normal_sleep || (sleep_wake && low_volt_supply_fail)) begin
      next_state.cause = `CAUSE_WAKE;
    end else if (state.pin_reset) begin
      next_state.cause = `CAUSE_PIN;
    end else if (SOURCES.config_check_fail) begin
      next_state.cause = `CAUSE_OPT;
    end else if (SOURCES.timer_expiry_reset) begin
      next_state.cause = `CAUSE_WDOG;
    end else if (SOURCES.cpu_soft_reset_req) begin
      next_state.cause = `CAUSE_SOFT;
    end
    if (CPU_LOCKUP) begin
      next_state.lockup = 1'b1;
    end else if (request.cpu_only_reset) begin
      next_state.lockup = 1'b0;
    end
    next_state.tap_reset = TAP_RESET_IN && !SERIAL_WIRE_MODE && !DEBUG_PORT_DISABLED;
  end

  // Full clear on RESETN; warm restarts come from the sources, never this pin
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state <= '{pin_count: '0, pin_reset: 1'b0, opt_fails: '0, opt_state: OPT_RUN,
                 opt_seen: 1'b0, cause: `CAUSE_NONE, lockup: 1'b0, tap_reset: 1'b0,
                 wake_pending: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  reset_release_sync u_cpu_debug (
    .clock(CLOCK), .request(request.cpu_debug_reset), .reset_out(RESETS.cpu_debug_reset));
  reset_release_sync u_cpu_only (
    .clock(CLOCK), .request(request.cpu_only_reset), .reset_out(RESETS.cpu_only_reset));
  reset_release_sync u_debug_access (
    .clock(CLOCK), .request(request.debug_access_reset),
    .reset_out(RESETS.debug_access_reset));
  reset_release_sync u_retained (
    .clock(CLOCK), .request(request.retained_periph_reset),
    .reset_out(RESETS.retained_periph_reset));
  reset_release_sync u_core (
    .clock(CLOCK), .request(request.core_periph_reset),
    .reset_out(RESETS.core_periph_reset));

  assign TAP_RESET = state.tap_reset;
  assign LAST_CAUSE = state.cause;
  assign LOCKUP_FLAG = state.lockup;
  assign FORCE_READ_PROTECT = state.opt_state == OPT_STOPPED;
  assign OPT_EMULATED_SLEEP = state.opt_state == OPT_STOPPED;
endmodule

// ===== logic/reset_gen_params.svh
/*
  Named constants of the reset generation block: filter times, counts, cause codes.
  Assumes a 250 MHz system clock; included by the package and the modules.
*/
`ifndef RESET_GEN_PARAMS_SVH
`define RESET_GEN_PARAMS_SVH

`define CLK_PERIOD_PS 4000
`define PIN_REJECT_NS 1000
`define PIN_ACCEPT_NS 26000
`define PIN_FILTER_NS 12000
`define PIN_FILTER_CYCLES ((`PIN_FILTER_NS * 1000) / `CLK_PERIOD_PS)
`define PIN_CNT_W 12
`define SYNC_STAGES 2
`define OPT_RETRY_LIMIT 2'h3
`define OPT_CNT_W 2
`define CAUSE_W 3
`define CAUSE_NONE 3'h0
`define CAUSE_AON 3'h1
`define CAUSE_LOWV 3'h2
`define CAUSE_PIN 3'h3
`define CAUSE_WDOG 3'h4
`define CAUSE_SOFT 3'h5
`define CAUSE_WAKE 3'h6
`define CAUSE_OPT 3'h7

`endif

// ===== logic/reset_gen_pkg.sv
/*
  Types shared by the reset generation modules.
  Assumes reset_gen_params.svh is on the include path.
*/
`include "reset_gen_params.svh"

package reset_gen_pkg;

  typedef struct packed {
    logic cpu_debug_reset;
    logic cpu_only_reset;
    logic debug_access_reset;
    logic retained_periph_reset;
    logic core_periph_reset;
  } reset_vec_t;

  typedef enum logic [2:0] {
    OPT_RUN = 3'h1,
    OPT_RETRY = 3'h2,
    OPT_STOPPED = 3'h4
  } opt_state_t;

  typedef struct packed {
    logic always_on_supply_fail;
    logic core_supply_fail;
    logic mem_supply_fail;
    logic timer_expiry_reset;
    logic cpu_soft_reset_req;
    logic config_check_fail;
    logic debugger_reset_req;
    logic normal_sleep;
    logic emulated_sleep;
    logic waking_from_sleep;
  } reset_src_t;

endpackage

// ===== logic/reset_release_sync.sv
/*
  One reset line: asserts at once, releases after two clean clock edges.
  Assumes the request is asynchronous to CLOCK; no other domain involved.
*/
`timescale 1ns/1ps
`include "reset_gen_params.svh"

module reset_release_sync (
  input wire logic clock,
  input wire logic request,
  output logic reset_out
);
  import reset_gen_pkg::*;

  logic [`SYNC_STAGES-1:0] chain;

  always_ff @(posedge clock or posedge request) begin
    if (request) begin
      chain <= '1;
    end else begin
      chain <= {chain[`SYNC_STAGES-2:0], 1'b0};
    end
  end

  assign reset_out = chain[`SYNC_STAGES-1];
endmodule

// ===== testbench/reset_gen_checker.sv
/* Assertions on the reset generation ports.
   Assumes it is bound into every reset_generation instance. */
`timescale 1ns/1ps
module reset_gen_checker (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire reset_gen_pkg::reset_src_t SOURCES,
  input wire logic EXT_PIN_RESET_N,
  input wire logic SERIAL_WIRE_MODE,
  input wire logic DEBUG_PORT_DISABLED,
  input wire logic CPU_LOCKUP,
  input wire reset_gen_pkg::reset_vec_t RESETS,
  input wire logic TAP_RESET,
  input wire logic LOCKUP_FLAG,
  input wire logic FORCE_READ_PROTECT,
  input wire logic OPT_EMULATED_SLEEP
);
  import reset_gen_pkg::*;
  logic [12:0] low_cnt;
  // Saturates at 26 us; longer lows need no count
  always_ff @(posedge CLOCK) begin
    if (EXT_PIN_RESET_N) begin
      low_cnt <= 13'h0;
    end else if (low_cnt != 13'h1964) begin
      low_cnt <= low_cnt + 13'h1;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  a_aon_all: assert property (SOURCES.always_on_supply_fail |-> RESETS == 5'h1f)
    else $error("aon fail without all resets");
  a_lowv_merge: assert property (SOURCES.mem_supply_fail |-> RESETS[4])
    else $error("memory fail without cpu reset");
  a_wdog_set: assert property (SOURCES.timer_expiry_reset |-> (RESETS & 5'h0b) == 5'h0b)
    else $error("watchdog pattern wrong");
  a_soft_set: assert property (SOURCES.cpu_soft_reset_req |-> (RESETS & 5'h0b) == 5'h0b)
    else $error("soft pattern wrong");
  a_opt_set: assert property (
    SOURCES.config_check_fail && !FORCE_READ_PROTECT |-> (RESETS & 5'h19) == 5'h19)
    else $error("option pattern wrong");
  a_sleep_hold: assert property (SOURCES.normal_sleep |-> (RESETS & 5'h1d) == 5'h1d)
    else $error("sleep pattern wrong");
  a_emu_set: assert property (SOURCES.emulated_sleep |-> (RESETS & 5'h09) == 5'h09)
    else $error("emulated pattern wrong");
  a_dbg_set: assert property (SOURCES.debugger_reset_req |-> RESETS.cpu_only_reset)
    else $error("debug request without cpu reset");
  a_sync_release: assert property (
    $fell(SOURCES.cpu_soft_reset_req) |-> RESETS.cpu_only_reset [*2])
    else $error("cpu reset released early");
  a_pin_long: assert property (low_cnt == 13'h1964 |-> (RESETS & 5'h1b) == 5'h1b)
    else $error("long pin low without reset");
  a_tap_gate: assert property (SERIAL_WIRE_MODE || DEBUG_PORT_DISABLED |=> !TAP_RESET)
    else $error("tap reset while gated");
  a_lock_flag: assert property (
    $rose(CPU_LOCKUP) && !RESETS.cpu_only_reset |=> LOCKUP_FLAG)
    else $error("lockup flag not set");
  a_opt_stop: assert property (
    OPT_EMULATED_SLEEP |-> FORCE_READ_PROTECT && (RESETS & 5'h09) == 5'h09)
    else $error("stopped without protection");
  c_pin: cover property (low_cnt == 13'h1964);
  c_stop: cover property ($rose(OPT_EMULATED_SLEEP));
  c_tap: cover property (TAP_RESET);
endmodule
bind reset_generation reset_gen_checker chk (.CLOCK, .RESETN, .SOURCES, .EXT_PIN_RESET_N,
  .SERIAL_WIRE_MODE, .DEBUG_PORT_DISABLED, .CPU_LOCKUP, .RESETS, .TAP_RESET,
  .LOCKUP_FLAG, .FORCE_READ_PROTECT, .OPT_EMULATED_SLEEP);

// ===== testbench/source_model.sv
/* Sources around the block: monitors, CPU, watchdog, debug port, power manager.
   Assumes the bench gives the wanted levels on req. */
`timescale 1ns/1ps
module source_model (
  input wire logic clock,
  input wire reset_gen_pkg::reset_src_t req,
  output reset_gen_pkg::reset_src_t src
);
  import reset_gen_pkg::*;
  // Levels move just after an edge
  always_ff @(posedge clock) begin
    src <= req;
  end
endmodule

// ===== testbench/reset_generation_tb.sv
/* Self-checking bench for reset generation.
   Assumes the source model feeds SOURCES; clock at 250 MHz. */
`timescale 1ns/1ps
`include "reset_gen_params.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module reset_generation_tb;
  import reset_gen_pkg::*;
  logic clock = 0, resetn = 0, pin_n = 1, done = 0, tap = 0, sw = 0, dis = 0, lock = 0;
  int checks = 0;
  int n_mismatch = 0;
  reset_src_t req = '0;
  reset_src_t src;
  reset_vec_t rst;
  logic tap_rst, lock_flag, frp, emu;
  logic [`CAUSE_W-1:0] cause;
  source_model SRC (.clock(clock), .req(req), .src(src));
  reset_generation DUT (.CLOCK(clock), .RESETN(resetn), .SOURCES(src),
    .EXT_PIN_RESET_N(pin_n), .OPT_CHECK_DONE(done), .TAP_RESET_IN(tap),
    .SERIAL_WIRE_MODE(sw), .DEBUG_PORT_DISABLED(dis), .CPU_LOCKUP(lock), .RESETS(rst),
    .TAP_RESET(tap_rst), .LAST_CAUSE(cause), .LOCKUP_FLAG(lock_flag),
    .FORCE_READ_PROTECT(frp), .OPT_EMULATED_SLEEP(emu));
  initial begin
    forever #2 clock = ~clock;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic step(input logic [9:0] v, input logic [4:0] e, input int w);
    @(posedge clock);
    req <= reset_src_t'(v);
    cyc(w);
    `CHK("resets", e, rst)
  endtask
  task automatic t_table;
    logic [4:0] er [7] = '{5'h1f, 5'h1f, 5'h1f, 5'h0b, 5'h0b, 5'h19, 5'h08};
    logic [2:0] ec [7] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h5, 3'h7, 3'h7};
    for (int i = 0; i < 7; i++) begin
      step(10'h200 >> i, er[i], 2);
      step(10'h000, 5'h00, 4);
      `CHK("cause", ec[i], cause)
    end
    $display("table done");
  endtask
  task automatic t_sleep;
    step(10'h004, 5'h1d, 2);
    step(10'h104, 5'h1d, 2);
    step(10'h101, 5'h1d, 2);
    step(10'h000, 5'h00, 4);
    step(10'h002, 5'h09, 2);
    step(10'h000, 5'h00, 4);
    $display("sleep done");
  endtask
  task automatic t_pin;
    @(posedge clock);
    pin_n <= 1'b0;
    repeat (250) @(posedge clock);
    pin_n <= 1'b1;
    cyc(2);
    `CHK("short pulse", 5'h00, rst)
    cyc(3100);
    @(posedge clock);
    pin_n <= 1'b0;
    cyc(6500);
    `CHK("pin", 5'h1b, rst)
    @(posedge clock);
    pin_n <= 1'b1;
    for (int i = 0; i < 3100 && rst !== 5'h00; i++) cyc(1);
    `CHK("pin release", 5'h00, rst)
    `CHK("pin cause", 3'h3, cause)
    $display("pin done");
  endtask
  task automatic t_tap;
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      tap <= 1'b1;
      sw <= (i == 1);
      dis <= (i == 2);
      cyc(3);
      `CHK("tap", 1'(i == 0), tap_rst)
      `CHK("tap others", 5'h00, rst)
    end
    @(posedge clock);
    tap <= 1'b0;
    lock <= 1'b1;
    cyc(3);
    `CHK("lockup", 1'b1, lock_flag)
    `CHK("no reset", 5'h00, rst)
    @(posedge clock);
    lock <= 1'b0;
    $display("tap lockup done");
  endtask
  task automatic t_opt;
    @(posedge clock);
    done <= 1'b1;
    @(posedge clock);
    done <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      step(10'h010, (i < 3) ? 5'h19 : 5'h09, 3);
      `CHK("protect", 1'(i >= 2), frp)
      `CHK("stopped", 1'(i >= 2), emu)
      step(10'h000, (i < 2) ? 5'h00 : 5'h09, 4);
    end
    $display("option done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    `CHK("in reset", 5'h1f, rst)
    resetn <= 1'b1;
    cyc(4);
    `CHK("after reset", 5'h00, rst)
    t_table();
    t_sleep();
    t_pin();
    t_tap();
    t_opt();
    finish_test();
  end
  // Run needs about 52 us; over twice that is a hang
  initial begin
    #120000;
    n_mismatch++;
    finish_test();
  end
endmodule
